// ==== inc/tai_params.svh ====
// constants for the interval timer channel: offsets, fields, resets
`ifndef TAI_PARAMS_SVH
`define TAI_PARAMS_SVH

// ==========================================================
// register byte offsets on the apb bus
`define TAI_OFF_CTRL      8'h00
`define TAI_OFF_MODE      8'h04
`define TAI_OFF_RELOAD    8'h08
`define TAI_OFF_COUNT     8'h0C
`define TAI_OFF_SRCSEL0   8'h10
`define TAI_OFF_SRCSEL1   8'h14
`define TAI_OFF_SRCSEL2   8'h18
`define TAI_OFF_INT_STAT  8'h1C
`define TAI_OFF_INT_MASK  8'h20

// ==========================================================
// field positions
`define TAI_CTRL_START_BIT   0
`define TAI_CTRL_PCLKSEL_BIT 1
`define TAI_INT_UF_BIT       0

// ==========================================================
// reset values
`define TAI_RST_CTRL      2'h0
`define TAI_RST_MODE      8'h00
`define TAI_RST_RELOAD    16'hFFFF
`define TAI_RST_SRCSEL    8'h00
`define TAI_RST_INT       1'h0

// ==========================================================
// channel served by this instance and prescaler ratios
`define TAI_CHANNEL       3'h0
`define TAI_SUB_DIV_MAX   5'h1F
`define TAI_DIV8_MASK     6'h07
`define TAI_DIV32_MASK    6'h1F
`define TAI_DIV64_MASK    6'h3F

`endif

// ==== inc/tai_pkg.sv ====
// types shared by the interval timer channel modules
package tai_pkg;

  // ==========================================================
  // gate choices; code 2'h1 is not defined and behaves as none
  typedef enum logic [1:0] {
    TAI_GATE_NONE = 2'h0,
    TAI_GATE_RSVD = 2'h1,
    TAI_GATE_LOW  = 2'h2,
    TAI_GATE_HIGH = 2'h3
  } tai_gate_e;

  // ==========================================================
  // channel mode register layout, msb first
  typedef struct packed {
    logic      legacy_clk_sel_hi;
    logic      legacy_clk_sel_lo;
    logic      pol_invert;
    tai_gate_e gate;
    logic      pulse_en;
    logic [1:0] rsvd;
  } tai_mode_s;

  // ==========================================================
  // one nibble of a source select register
  typedef struct packed {
    logic       src_option;
    logic [2:0] src_code;
  } tai_srcsel_s;

endpackage

// ==== design/tai_src_sel.sv ====
// count source prescaler and selector for one timer channel
`include "tai_params.svh"

module tai_src_sel
  import tai_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        peripheral_clk_div_sel,
  input  wire tai_srcsel_s srcsel,
  input  wire logic [1:0]  legacy_sel,
  input  wire logic        osc_tick,
  input  wire logic        subclk_tick,
  output logic             count_tick
);

  logic [5:0] pre_reg;
  logic [5:0] pre_next;
  logic [4:0] sub_reg;
  logic [4:0] sub_next;
  logic       div1;
  logic       div2;
  logic       div8;
  logic       div32;
  logic       div64;
  logic       subclock_div32;
  logic       base;

  // ==========================================================
  // free prescaler, sub-clock divider by 32
  always_comb begin
    pre_next = pre_reg + 6'h01;
    sub_next = subclk_tick ? sub_reg + 5'h01 : sub_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 6'h00;
      sub_reg <= 5'h00;
    end else begin
      pre_reg <= pre_next;
      sub_reg <= sub_next;
    end
  end

  // ==========================================================
  // divided ticks are one pclk wide enables
  assign div1  = 1'b1;
  assign div2  = pre_reg[0];
  assign div8  = (pre_reg & `TAI_DIV8_MASK) == `TAI_DIV8_MASK;
  assign div32 = (pre_reg & `TAI_DIV32_MASK) == `TAI_DIV32_MASK;
  assign div64 = pre_reg == `TAI_DIV64_MASK;
  assign subclock_div32 = subclk_tick && (sub_reg == `TAI_SUB_DIV_MAX);
  assign base  = peripheral_clk_div_sel ? div1 : div2;

  // ==========================================================
  // source choice: legacy bits or the three-bit code
  always_comb begin
    count_tick = 1'b0;
    if (!srcsel.src_option) begin
      unique case (legacy_sel)
        2'h0: count_tick = base;
        2'h1: count_tick = div8;
        2'h2: count_tick = div32;
        2'h3: count_tick = subclock_div32;
      endcase
    end else begin
      unique case (srcsel.src_code)
        3'h0: count_tick = base;
        3'h1: count_tick = div8;
        3'h2: count_tick = div32;
        3'h3: count_tick = div64;
        3'h5: count_tick = osc_tick;
        3'h6: count_tick = subclock_div32;
        default: count_tick = 1'b0; // reserved codes never count
      endcase
    end
  end

  a_legacy_div8: assert property (@(posedge pclk) disable iff (!presetn)
    (!srcsel.src_option && legacy_sel == 2'h1) |-> count_tick == div8)
    else $error("legacy select 01 not div8");
  a_reserved_src: assert property (@(posedge pclk) disable iff (!presetn)
    (srcsel.src_option && srcsel.src_code == 3'h4) |-> !count_tick)
    else $error("reserved source produced a tick");
  a_base_div2: assert property (@(posedge pclk) disable iff (!presetn)
    (!peripheral_clk_div_sel && !srcsel.src_option && legacy_sel == 2'h0
     && count_tick) |=> !count_tick || peripheral_clk_div_sel ||
    srcsel.src_option || legacy_sel != 2'h0)
    else $error("halved base clock ticked twice in a row");

endmodule // tai_src_sel

// ==== design/tai_pulse_out.sv ====
// pulse output stage: toggles on underflow, polarity selectable
module tai_pulse_out (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pulse_en,
  input  wire logic pol_invert,
  input  wire logic underflow,
  output logic      pulse_out
);

  logic tog_reg;
  logic tog_next;
  logic out_next;

  // ==========================================================
  // toggle restarts from idle when disabled so the first edge is active
  always_comb begin
    tog_next = pulse_en ? (tog_reg ^ underflow) : 1'b0;
    out_next = pulse_en ? (tog_next ^ pol_invert) : 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_reg   <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      tog_reg   <= tog_next;
      pulse_out <= out_next;
    end
  end

  a_pulse_off: assert property (@(posedge pclk) disable iff (!presetn)
    !pulse_en |=> !pulse_out)
    else $error("pulse output active while disabled");

endmodule // tai_pulse_out

// ==== design/tai_top.sv ====
// interval mode timer channel with apb registers and interrupt
`include "tai_params.svh"

module tai_top
  import tai_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        gate_input_pin,
  input  wire logic        osc_tick,
  input  wire logic        subclk_tick,
  output logic             pulse_out,
  output logic             irq
);

  // ==========================================================
  // register state
  logic        start_reg;
  logic        start_next;
  logic        pclksel_reg;
  logic        pclksel_next;
  tai_mode_s   mode_reg;
  tai_mode_s   mode_next;
  logic [15:0] reload_reg;
  logic [15:0] reload_next;
  logic [7:0]  src0_reg;
  logic [7:0]  src0_next;
  logic [7:0]  src1_reg;
  logic [7:0]  src1_next;
  logic [3:0]  src2_reg;
  logic [3:0]  src2_next;
  logic        stat_reg;
  logic        stat_next;
  logic        mask_reg;
  logic        mask_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [31:0] prdata_next;
  logic        pready_next;
  logic        pslverr_next;
  logic        irq_next;

  logic        commit;
  logic        wr;
  logic        mapped;
  logic        reload_wr;
  logic        tick;
  logic        gate_ok;
  logic        underflow;
  tai_srcsel_s chan_src;

  // ==========================================================
  // nibble of the source select registers that this channel uses
  function automatic tai_srcsel_s pick_src(
    input logic [2:0] ch,
    input logic [7:0] s0,
    input logic [7:0] s1,
    input logic [3:0] s2
  );
    tai_srcsel_s r;
    r = tai_srcsel_s'(4'h0);
    unique case (ch)
      3'h0: r = tai_srcsel_s'(s0[3:0]);
      3'h1: r = tai_srcsel_s'(s0[7:4]);
      3'h2: r = tai_srcsel_s'(s1[3:0]);
      3'h3: r = tai_srcsel_s'(s1[7:4]);
      3'h4: r = tai_srcsel_s'(s2);
      default: r = tai_srcsel_s'(4'h0);
    endcase
    return r;
  endfunction

  // address decode, shared by the read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    return a == `TAI_OFF_CTRL || a == `TAI_OFF_MODE ||
           a == `TAI_OFF_RELOAD || a == `TAI_OFF_COUNT ||
           a == `TAI_OFF_SRCSEL0 || a == `TAI_OFF_SRCSEL1 ||
           a == `TAI_OFF_SRCSEL2 || a == `TAI_OFF_INT_STAT ||
           a == `TAI_OFF_INT_MASK;
  endfunction

  assign chan_src = pick_src(`TAI_CHANNEL, src0_reg, src1_reg, src2_reg);

  // ==========================================================
  // count source and pulse output stages
  tai_src_sel u_src_sel (
    .pclk                   (pclk),
    .presetn                (presetn),
    .peripheral_clk_div_sel (pclksel_reg),
    .srcsel                 (chan_src),
    .legacy_sel             ({mode_reg.legacy_clk_sel_hi,
                              mode_reg.legacy_clk_sel_lo}),
    .osc_tick               (osc_tick),
    .subclk_tick            (subclk_tick),
    .count_tick             (tick)
  );

  tai_pulse_out u_pulse_out (
    .pclk       (pclk),
    .presetn    (presetn),
    .pulse_en   (mode_reg.pulse_en),
    .pol_invert (mode_reg.pol_invert),
    .underflow  (underflow),
    .pulse_out  (pulse_out)
  );

  // ==========================================================
  // apb handshake: one wait state keeps every output registered
  assign commit    = psel && penable && pready;
  assign wr        = commit && pwrite;
  assign mapped    = is_mapped(paddr);
  assign reload_wr = wr && paddr == `TAI_OFF_RELOAD;

  always_comb begin
    pready_next  = psel && penable && !pready;
    pslverr_next = pready_next && !mapped;
    prdata_next  = 32'h0000_0000;
    if (pready_next && !pwrite) begin
      unique case (paddr)
        `TAI_OFF_CTRL:     prdata_next = {30'h0, pclksel_reg, start_reg};
        `TAI_OFF_MODE:     prdata_next = {24'h0, mode_reg};
        `TAI_OFF_RELOAD:   prdata_next = {16'h0, reload_reg};
        `TAI_OFF_COUNT:    prdata_next = {16'h0, count_reg};
        `TAI_OFF_SRCSEL0:  prdata_next = {24'h0, src0_reg};
        `TAI_OFF_SRCSEL1:  prdata_next = {24'h0, src1_reg};
        `TAI_OFF_SRCSEL2:  prdata_next = {28'h0, src2_reg};
        `TAI_OFF_INT_STAT: prdata_next = {31'h0, stat_reg};
        `TAI_OFF_INT_MASK: prdata_next = {31'h0, mask_reg};
        default:           prdata_next = 32'h0000_0000; // unmapped
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= pready_next;
      pslverr <= pslverr_next;
      prdata  <= prdata_next;
    end
  end

  // ==========================================================
  // software writable configuration
  always_comb begin
    start_next   = start_reg;
    pclksel_next = pclksel_reg;
    mode_next    = mode_reg;
    reload_next  = reload_reg;
    src0_next    = src0_reg;
    src1_next    = src1_reg;
    src2_next    = src2_reg;
    mask_next    = mask_reg;
    if (wr) begin
      unique case (paddr)
        `TAI_OFF_CTRL: begin
          start_next   = pwdata[`TAI_CTRL_START_BIT];
          pclksel_next = pwdata[`TAI_CTRL_PCLKSEL_BIT];
        end
        `TAI_OFF_MODE:     mode_next   = tai_mode_s'(pwdata[7:0]);
        `TAI_OFF_RELOAD:   reload_next = pwdata[15:0];
        `TAI_OFF_SRCSEL0:  src0_next   = pwdata[7:0];
        `TAI_OFF_SRCSEL1:  src1_next   = pwdata[7:0];
        `TAI_OFF_SRCSEL2:  src2_next   = pwdata[3:0];
        `TAI_OFF_INT_MASK: mask_next   = pwdata[`TAI_INT_UF_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg   <= 1'b0;
      pclksel_reg <= 1'b0;
      mode_reg    <= tai_mode_s'(`TAI_RST_MODE);
      reload_reg  <= `TAI_RST_RELOAD;
      src0_reg    <= `TAI_RST_SRCSEL;
      src1_reg    <= `TAI_RST_SRCSEL;
      src2_reg    <= 4'h0;
      mask_reg    <= `TAI_RST_INT;
    end else begin
      start_reg   <= start_next;
      pclksel_reg <= pclksel_next;
      mode_reg    <= mode_next;
      reload_reg  <= reload_next;
      src0_reg    <= src0_next;
      src1_reg    <= src1_next;
      src2_reg    <= src2_next;
      mask_reg    <= mask_next;
    end
  end

  // ==========================================================
  // gate qualification; the undefined code counts ungated
  always_comb begin
    unique case (mode_reg.gate)
      TAI_GATE_LOW:  gate_ok = !gate_input_pin;
      TAI_GATE_HIGH: gate_ok = gate_input_pin;
      default:       gate_ok = 1'b1;
    endcase
  end

  // ==========================================================
  // down counter; a reload write while stopped also presets it
  assign underflow = start_reg && tick && gate_ok &&
                     count_reg == 16'h0000;

  always_comb begin
    count_next = count_reg; // held when stopped
    if (reload_wr && !start_reg) begin
      count_next = pwdata[15:0];
    end else if (underflow) begin
      count_next = reload_reg;
    end else if (start_reg && tick && gate_ok) begin
      count_next = count_reg - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `TAI_RST_RELOAD;
    end else begin
      count_reg <= count_next;
    end
  end

  // ==========================================================
  // sticky request bit: an underflow in the clearing cycle wins
  always_comb begin
    stat_next = stat_reg;
    if (wr && paddr == `TAI_OFF_INT_STAT && pwdata[`TAI_INT_UF_BIT]) begin
      stat_next = 1'b0;
    end
    if (underflow) begin
      stat_next = 1'b1;
    end
    irq_next = stat_next && mask_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= `TAI_RST_INT;
      irq      <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq      <= irq_next;
    end
  end

  // ==========================================================
  // checks
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    psel && penable && !pready ##1 pready;
  endsequence

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup ##1 (psel && penable) |-> ##1 pready)
    else $error("apb access not answered after one wait state");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (start_reg && tick && gate_ok && count_reg != 16'h0000)
    |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("counter did not decrement on a tick");
  // a stop written in the underflow cycle legally clears the start flag
  a_uf_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (underflow && !(wr && paddr == `TAI_OFF_CTRL))
    |=> count_reg == $past(reload_reg) && start_reg)
    else $error("underflow did not reload");
  a_uf_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (underflow && mask_reg && !(wr && paddr == `TAI_OFF_INT_MASK))
    |=> stat_reg ##0 irq)
    else $error("underflow did not raise request");
  a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!start_reg && !reload_wr) |=> $stable(count_reg))
    else $error("stopped counter changed");
  a_gate_block: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg.gate == TAI_GATE_LOW && gate_input_pin && !reload_wr)
    |=> $stable(count_reg))
    else $error("counted while low gate closed");
  a_clear_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (stat_reg && !wr) |=> stat_reg)
    else $error("request bit dropped without a clear");

endmodule // tai_top

// ==== tb/tb_top.sv ====
// self-checking bench for the interval timer channel
`include "tai_params.svh"

// ==========================================================
// one compare, counted; a mismatch is reported at once
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, b); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [31:0] data;
    logic        err;
    logic        rd;
  } tai_tb_exp_s;

  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        gate_input_pin;
  logic        osc_tick;
  logic        subclk_tick;
  logic        pulse_out;
  logic        irq;
  int          error_cnt = 0;
  int          compares = 0;
  int          tick_cnt = 0;
  tai_tb_exp_s exp_q[$];
  tai_tb_exp_s got_x;
  logic [15:0] rv;
  logic [7:0]  r8;

  // ctrl, mode, srcsel0, gate pin (2 = random), period multiplier
  localparam logic [39:0] TBL [20] = '{
    40'h0304000201, 40'h0104000202, 40'h0344030208, 40'h0384000220,
    40'h03C4000240, 40'h03C4080201, 40'h0304090208, 40'h03040A0220,
    40'h03040B0240, 40'h03040D0204, 40'h03040E0240, 40'h0304B00201,
    40'h0314000100, 40'h0314000001, 40'h031C000000, 40'h031C000101,
    40'h030C000201, 40'h0324000201, 40'h0204000200, 40'h0300000200};

  tai_top i_dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .gate_input_pin (gate_input_pin),
    .osc_tick       (osc_tick),
    .subclk_tick    (subclk_tick),
    .pulse_out      (pulse_out),
    .irq            (irq)
  );

  // ==========================================================
  // clock and free running source ticks
  always #12.5 pclk = ~pclk;

  // oscillator every 4th cycle, sub-clock every 2nd to keep runs short
  always @(posedge pclk) begin
    tick_cnt    <= tick_cnt + 1;
    osc_tick    <= (tick_cnt[1:0] == 2'h3);
    subclk_tick <= tick_cnt[0];
  end

  // ==========================================================
  // apb master: note the expectation, run one transfer
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic err);
    tai_tb_exp_s x;
    int          n;
    x.data = e;
    x.err  = err;
    x.rd   = !wr;
    exp_q.push_back(x);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    `CHK(pready, 1'b1)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic err = 1'b0);
    apb(1'b1, a, d, 32'h0, err);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic err = 1'b0);
    apb(1'b0, a, 32'h0, e, err);
  endtask

  // ==========================================================
  // monitor: each finished transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("[ERR] %0t transfer without expectation", $time);
      end else begin
        got_x = exp_q.pop_front();
        `CHK(pslverr, got_x.err)
        if (got_x.rd) `CHK(prdata, got_x.data)
      end
    end
  end

  // ==========================================================
  // pulse period: sync to one toggle, then count to the next
  task automatic measure(input int per);
    logic prev;
    int   n;
    int   m;
    n = 0;
    for (m = 0; m < 2; m++) begin
      prev = pulse_out;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pulse_out === prev && n < 1500);
    end
    if (per == 0) begin
      `CHK(n, 1500)
      `CHK(pulse_out, 1'b0)
    end else begin
      `CHK(n, per)
    end
  endtask

  // re-enabling the output forces it back to its inactive level
  task automatic run_cfg(input logic [39:0] t, input logic [15:0] rl);
    wr(`TAI_OFF_CTRL, 32'h0);
    wr(`TAI_OFF_MODE, 32'h0);
    wr(`TAI_OFF_MODE, {24'h0, t[31:24]});
    wr(`TAI_OFF_SRCSEL0, {24'h0, t[23:16]});
    wr(`TAI_OFF_RELOAD, {16'h0, rl});
    `CHK(pulse_out, t[29] & t[26])
    if (t[15:8] == 8'h02) begin
      gate_input_pin <= 1'($urandom_range(1, 0));
    end else begin
      gate_input_pin <= t[8];
    end
    wr(`TAI_OFF_CTRL, {24'h0, t[39:32]});
    measure(int'(t[7:0]) * (int'(rl) + 1));
  endtask

  // ==========================================================
  // verdict, reached from the sequence or the watchdog
  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #(90000 * 25);
    error_cnt++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(34441));
    presetn        = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 8'h00;
    pwdata         = 32'h0;
    gate_input_pin = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values
    rd(`TAI_OFF_CTRL, 32'(`TAI_RST_CTRL));
    rd(`TAI_OFF_MODE, 32'(`TAI_RST_MODE));
    rd(`TAI_OFF_RELOAD, 32'(`TAI_RST_RELOAD));
    rd(`TAI_OFF_COUNT, 32'(`TAI_RST_RELOAD));
    rd(`TAI_OFF_SRCSEL0, 32'(`TAI_RST_SRCSEL));
    rd(`TAI_OFF_INT_STAT, 32'(`TAI_RST_INT));
    rd(`TAI_OFF_INT_MASK, 32'(`TAI_RST_INT));
    // unmapped place and read-only count
    wr(8'h24, 32'hFFFFFFFF, 1'b1);
    rd(8'h24, 32'h0, 1'b1);
    rv = 16'($urandom_range(32'hFFFF, 32'h0100));
    wr(`TAI_OFF_RELOAD, {16'h0, rv});
    rd(`TAI_OFF_COUNT, {16'h0, rv});
    wr(`TAI_OFF_COUNT, 32'h55);
    rd(`TAI_OFF_COUNT, {16'h0, rv});
    // gate closed: started counter must not move
    wr(`TAI_OFF_MODE, 32'h10);
    gate_input_pin <= 1'b1;
    wr(`TAI_OFF_CTRL, 32'h3);
    repeat (20) @(posedge pclk);
    rd(`TAI_OFF_COUNT, {16'h0, rv});
    wr(`TAI_OFF_CTRL, 32'h0);
    // other channels' nibbles are stored as written
    r8 = 8'($urandom);
    wr(`TAI_OFF_SRCSEL1, {24'h0, r8});
    wr(`TAI_OFF_SRCSEL2, {24'h0, ~r8});
    rd(`TAI_OFF_SRCSEL1, {24'h0, r8});
    rd(`TAI_OFF_SRCSEL2, {28'h0, ~r8[3:0]});
    // every source, gate and output setting, random reload
    for (int i = 0; i < 20; i++) begin
      run_cfg(TBL[i], 16'($urandom_range(9, 2)));
    end
    // interrupt: set while masked, unmask, w1c clear, set again
    wr(`TAI_OFF_CTRL, 32'h0);
    rd(`TAI_OFF_INT_STAT, 32'h1);
    `CHK(irq, 1'b0)
    wr(`TAI_OFF_INT_STAT, 32'h0);
    rd(`TAI_OFF_INT_STAT, 32'h1);
    wr(`TAI_OFF_INT_MASK, 32'h1);
    rd(`TAI_OFF_INT_MASK, 32'h1);
    `CHK(irq, 1'b1)
    wr(`TAI_OFF_INT_STAT, 32'h1);
    rd(`TAI_OFF_INT_STAT, 32'h0);
    `CHK(irq, 1'b0)
    wr(`TAI_OFF_CTRL, 32'h3);
    repeat (100) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(`TAI_OFF_CTRL, 32'h0);
    stop_test();
  end

endmodule // tb_top
